//--- spl_pkg.sv
// Package for the serial-in parallel latch driver block.
// Assumes a single 50 MHz system clock; all pin inputs are asynchronous.
package spl_pkg;

    // Datapath sizes: stage count and queue depth
    localparam int STAGE_COUNT = 8;
    localparam int FIFO_DEPTH = 8;

    // Reset values
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic [7:0] OE_N_RESET = 8'hff;
    localparam logic [7:0] SINK_DATA_RESET = 8'h00;

    // Timing: system clock and the least shift-to-strobe spacing
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_SU_STROBE_NS = 50;
    localparam int SU_STROBE_CYCLES = (T_SU_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SU_CNT_RESET = 4'h0;

    // One sampled set of control pins
    typedef struct packed {
        logic data;
        logic shift_clk;
        logic strobe;
        logic clear_n;
        logic blank;
    } spl_pins_type;

    // Pin levels held while in reset: the idle level of every pin
    localparam spl_pins_type PINS_RESET = '{data: 1'b0, shift_clk: 1'b0, strobe: 1'b0,
                                           clear_n: 1'b1, blank: 1'b1};

    // Pattern word passed from shift stage to latch stage
    typedef struct packed {
        logic [7:0] pattern;
    } spl_word_type;

    // Latch loader state
    typedef enum logic [1:0] {
        SPL_IDLE = 2'b01,
        SPL_LOAD = 2'b10
    } spl_state_type;

endpackage : spl_pkg

//--- spl_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module spl_fifo
    import spl_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest full and empty from the count
    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];

    // Pointers and occupancy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage, written by index
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule // spl_fifo

//--- spl_driver.sv
// Serial-in parallel-out latch driver with blanked open-drain sink outputs.
// Assumes all pins are asynchronous to MCLK and the shift clock is far slower.
// Assumes the host holds each shift clock level for two MCLK cycles or more.
// Assumes the sink pins are open drain: a sink is on while its enable is low.
// Assumes strobes come tens of MCLK cycles apart, far slower than the loader.
// The clear input reaches the shift stages only; the latches keep their data.
// What this block does
// RQ1: Shift clock rise captures serial data input
// RQ2: Each stage passes content toward cascade output
// RQ3: Strobe rise copies all stages into latches
// RQ4: Blank high switches off all sink drivers
// RQ5: Blanking never alters stored latch contents
// RQ6: Blank low: each driver follows its latch
// RQ7: Clear low forces shift stages to zero
// RQ8: Push-pull cascade output carries shifted-out data
// RQ9: Controller waits 50 ns shift-to-strobe; block only flags a sooner strobe on STROBE_EARLY
// RQ10: Eight stages, eight latches, eight drivers
// RQ11: Cascade output shows last stage content
`timescale 1ns/100ps
module spl_driver
    import spl_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic SER_IN,
    input wire logic SHIFT_CLK,
    input wire logic STROBE_IN,
    input wire logic CLEAR_N,
    input wire logic BLANK_IN,
    output logic [3:0] SINK_DRIVE_LOW_O,
    output logic [3:0] SINK_DRIVE_LOW_OE_N,
    output logic [3:0] SINK_DRIVE_HIGH_O,
    output logic [3:0] SINK_DRIVE_HIGH_OE_N,
    output logic SER_OUT,
    output logic STROBE_EARLY
);
    // Two-stage synchronisers for every pin, plus a delayed copy for edges
    spl_pins_type meta_ff;
    spl_pins_type sync_ff;
    spl_pins_type prev_ff;

    // Shift stages and the cascade flop behind them
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic ser_out_ff;

    // Output latches and the sink enables they feed
    logic [7:0] latch_ff;
    logic [7:0] nxt_latch;
    logic [7:0] nxt_drive;
    logic [7:0] oe_n_ff;
    logic [7:0] sink_data_ff;

    // Shift-to-strobe spacing watch
    logic early_ff;
    logic nxt_early;
    logic [3:0] su_cnt_ff;
    logic [3:0] nxt_su_cnt;

    // Loader between the strobe queue and the latches
    spl_state_type state_ff;
    spl_state_type nxt_state;
    spl_word_type fifo_in;
    spl_word_type fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;

    // Raw pin bundle, read only by the first flop. The pins are driven
    // by a host on another clock, so no logic may look at them before
    // they have passed both synchroniser flops.
    spl_pins_type pins_raw;
    assign pins_raw = '{data: SER_IN, shift_clk: SHIFT_CLK, strobe: STROBE_IN,
                        clear_n: CLEAR_N, blank: BLANK_IN};

    // First flop: may go metastable, so nothing but the second flop reads it
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            meta_ff <= PINS_RESET;
        end else begin
            meta_ff <= pins_raw;
        end
    end

    // Second flop: the settled copy every piece of logic works from
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            sync_ff <= PINS_RESET;
        end else begin
            sync_ff <= meta_ff;
        end
    end

    // Delayed copy for edge finding; reset to the idle pin levels so that
    // leaving reset never looks like a shift clock or strobe edge
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            prev_ff <= PINS_RESET;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    // Edge detection on synchronised shift clock and strobe. Both inputs
    // of the function come from settled flops, so one pin edge gives
    // exactly one single-cycle pulse.
    function automatic logic rose(input logic now, input logic was);
        rose = now && !was;
    endfunction

    wire shift_rise = rose(sync_ff.shift_clk, prev_ff.shift_clk);
    wire strobe_rise = rose(sync_ff.strobe, prev_ff.strobe);

    // Latency seen from the pins, in MCLK edges after a pin edge:
    // edge 1 meta, edge 2 sync (edge flagged), edge 3 shift stages and
    // cascade. A strobe is queued at edge 3, the loader moves to its load
    // state at edge 4, and the latch and the sink enables take the pattern
    // together at edge 5. Blanking reaches the enables at edge 3.
    // The cost is a few cycles of delay against a shift clock that is many
    // times slower, bought for glitch-free edge detection.

    // Limits a user must know: a shift clock level shorter than two MCLK
    // cycles may be missed, since both flops must see it; data must be
    // steady at the second flop when the shift clock edge arrives there,
    // which the host gives by changing data well away from the rise.
    // The strobe is taken on its rising edge only, its width is not used.

    // One stage's next value; clear wins over a shift in the same cycle
    function automatic logic stage_next(input logic clr_n, input logic step,
                                        input logic below, input logic held);
        if (!clr_n) begin
            stage_next = SHIFT_RESET[0];
        end else if (step) begin
            stage_next = below;
        end else begin
            stage_next = held;
        end
    endfunction

    // Bit shifted into stage 0: the serial input on a shift clock rise
    wire logic stage_in = sync_ff.data; // [RQ1]

    // Each stage: clear dominates, else take the stage below on a rise
    for (genvar gi = 0; gi < STAGE_COUNT; gi++) begin : g_stage
        if (gi == 0) begin : g_first
            assign nxt_shift[gi] = stage_next(sync_ff.clear_n, shift_rise, stage_in,
                                              shift_ff[gi]); // [RQ1] [RQ7]
        end else begin : g_rest
            assign nxt_shift[gi] = stage_next(sync_ff.clear_n, shift_rise, shift_ff[gi-1],
                                              shift_ff[gi]); // [RQ2] [RQ7] [RQ10]
        end
    end

    // Shift stages; reset and clear both leave them all zero, so a
    // cleared chain shifts out zeros until new data arrives
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            shift_ff <= SHIFT_RESET;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    // Cascade output is the last stage, always driven both ways. It is
    // taken from the next-state value so that it moves in the same cycle
    // as the stages and the next device in a chain sees no extra delay.
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            ser_out_ff <= 1'b0;
        end else begin
            ser_out_ff <= nxt_shift[STAGE_COUNT-1]; // [RQ8] [RQ11]
        end
    end

    // Spacing since the last shift edge, flagged if a strobe comes too
    // soon. The count saturates at the window length, so a small counter
    // covers any gap however long.
    assign nxt_su_cnt = shift_rise ? SU_CNT_RESET
                      : (su_cnt_ff < 4'(SU_STROBE_CYCLES)) ? su_cnt_ff + 4'h1
                      : su_cnt_ff;

    // Starts saturated, so a strobe straight after reset is not called early
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            su_cnt_ff <= 4'(SU_STROBE_CYCLES);
        end else begin
            su_cnt_ff <= nxt_su_cnt;
        end
    end

    // Strobe inside the spacing window; it still loads, only the flag tells
    assign nxt_early = strobe_rise && (su_cnt_ff < 4'(SU_STROBE_CYCLES)); // [RQ9]

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            early_ff <= 1'b0;
        end else begin
            early_ff <= nxt_early;
        end
    end

    // Snapshot of stages queued to the latch stage on strobe
    assign fifo_in.pattern = shift_ff;
    // A strobe that meets a full queue is lost; strobes are tens of cycles
    // apart and the loader drains one pattern every two cycles
    wire fifo_push = strobe_rise && fifo_in_ready; // [RQ3]

    // Eight-deep queue between strobe capture and the latches. Its depth
    // far exceeds need at the usual strobe rate; it keeps a burst of
    // close strobes from being lost while the loader works through them,
    // at the cost of a few cycles of latency on every load.
    spl_fifo #(
        .WIDTH(STAGE_COUNT),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RESET_N),
        .in_data(fifo_in),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    // Latch loader: takes one queued pattern per two cycles. The idle
    // state only notices a waiting pattern; the load state pops it and
    // writes the latches, so a pattern is never applied twice by a
    // strobe that is still high.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SPL_IDLE: begin
                if (fifo_out_valid) begin
                    nxt_state = SPL_LOAD;
                end
            end
            SPL_LOAD: nxt_state = SPL_IDLE;
            default: nxt_state = SPL_IDLE;
        endcase
    end

    // Pop only in the load state, one pattern per visit
    assign fifo_pop = (state_ff == SPL_LOAD) && fifo_out_valid;
    // Latch input: the queued pattern while popping, else hold
    assign nxt_latch = fifo_pop ? fifo_out.pattern : latch_ff; // [RQ3] [RQ5]

    // Loader state
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            state_ff <= SPL_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Latches hear only the loader: clear and blanking never reach them
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            latch_ff <= LATCH_RESET;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    // Blanking gates the drivers only, never the latches, so the held
    // pattern comes back unchanged when blanking is lifted
    function automatic logic sink_on(input logic blank_now, input logic held);
        sink_on = !blank_now && held;
    endfunction

    // One enable flop per sink, low while sinking; the pin comes straight from it
    for (genvar go = 0; go < STAGE_COUNT; go++) begin : g_sink
        assign nxt_drive[go] = sink_on(sync_ff.blank, nxt_latch[go]); // [RQ4] [RQ5] [RQ6]

        always_ff @(posedge MCLK) begin
            if (!RESET_N) begin
                oe_n_ff[go] <= OE_N_RESET[go];
            end else begin
                oe_n_ff[go] <= !nxt_drive[go]; // [RQ10]
            end
        end
    end

    // Open drain data is always low; it is a flop only so that every pin
    // comes straight from a register
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            sink_data_ff <= SINK_DATA_RESET;
        end else begin
            sink_data_ff <= SINK_DATA_RESET;
        end
    end

    // Pins: low nibble serves outputs 0-3, high nibble outputs 4-7
    assign SINK_DRIVE_LOW_O = sink_data_ff[3:0];
    assign SINK_DRIVE_HIGH_O = sink_data_ff[7:4];
    assign SINK_DRIVE_LOW_OE_N = oe_n_ff[3:0];
    assign SINK_DRIVE_HIGH_OE_N = oe_n_ff[7:4];
    assign SER_OUT = ser_out_ff;
    assign STROBE_EARLY = early_ff;
endmodule // spl_driver

//--- spl_driver_monitor.sv
// Checker for the latch driver's pin behaviour.
// Sees only the top ports; bound into every spl_driver.
`timescale 1ns/100ps
module spl_driver_monitor (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic SER_IN,
    input wire logic SHIFT_CLK,
    input wire logic STROBE_IN,
    input wire logic CLEAR_N,
    input wire logic BLANK_IN,
    input wire logic [3:0] SINK_DRIVE_LOW_O,
    input wire logic [3:0] SINK_DRIVE_LOW_OE_N,
    input wire logic [3:0] SINK_DRIVE_HIGH_O,
    input wire logic [3:0] SINK_DRIVE_HIGH_OE_N,
    input wire logic SER_OUT,
    input wire logic STROBE_EARLY
);
    logic [7:0] oe_n;
    assign oe_n = {SINK_DRIVE_HIGH_OE_N, SINK_DRIVE_LOW_OE_N};
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // Pin sync costs about three cycles, so windows allow for it
    blank_hold_a: assert property (BLANK_IN [*6] |-> oe_n == 8'hff)
        else $error("sink on while blanked");
    blank_rise_a: assert property ($rose(BLANK_IN) |-> ##[1:6] oe_n == 8'hff)
        else $error("blank too slow");
    outs_zero_a: assert property ({SINK_DRIVE_HIGH_O, SINK_DRIVE_LOW_O} == 8'h00)
        else $error("sink data not low");
    ser_hold_a: assert property ((CLEAR_N && $stable(SHIFT_CLK)) [*6] |=> $stable(SER_OUT))
        else $error("cascade moved without shift");
    clear_zero_a: assert property ((!CLEAR_N) [*6] |-> !SER_OUT)
        else $error("cascade high under clear");
    oe_hold_a: assert property ((!$changed(STROBE_IN) && !$changed(BLANK_IN)) [*8] |=> $stable(oe_n))
        else $error("sinks moved without cause");
    early_pulse_a: assert property (STROBE_EARLY |=> !STROBE_EARLY)
        else $error("early flag longer than one cycle");
    early_cause_a: assert property ((!STROBE_IN) [*8] |-> !STROBE_EARLY)
        else $error("early flag without strobe");
endmodule // spl_driver_monitor

bind spl_driver spl_driver_monitor i_mon (.MCLK(MCLK), .RESET_N(RESET_N), .SER_IN(SER_IN),
    .SHIFT_CLK(SHIFT_CLK), .STROBE_IN(STROBE_IN), .CLEAR_N(CLEAR_N), .BLANK_IN(BLANK_IN),
    .SINK_DRIVE_LOW_O(SINK_DRIVE_LOW_O), .SINK_DRIVE_LOW_OE_N(SINK_DRIVE_LOW_OE_N),
    .SINK_DRIVE_HIGH_O(SINK_DRIVE_HIGH_O), .SINK_DRIVE_HIGH_OE_N(SINK_DRIVE_HIGH_OE_N),
    .SER_OUT(SER_OUT), .STROBE_EARLY(STROBE_EARLY));

//--- spl_host_model.sv
// Host controller model: shifts a byte out, then strobes it.
// Assumes mclk is the 20 ns system clock; link clock is 160 ns.
`timescale 1ns/100ps
module spl_host_model (
    input wire logic mclk,
    output logic ser,
    output logic sclk,
    output logic strobe
);
    initial begin
        ser = 1'b0;
        sclk = 1'b0;
        strobe = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // Msb first; data scrambled after hold so stale bits are not trusted
    task automatic send(input logic [7:0] val, input logic early);
        for (int i = 7; i >= 0; i--) begin
            ser = val[i];
            wait_n(4);
            sclk = 1;
            wait_n(2);
            ser = ~ser; // Held two cycles past the rise, then scrambled
            if (i == 0 && early) begin
                strobe = 1; // Deliberately too soon after the shift edge
            end
            wait_n(2);
            sclk = 0;
        end
        if (!early) begin
            wait_n(3);
            strobe = 1;
        end
        wait_n(4);
        strobe = 0;
    endtask
endmodule // spl_host_model

//--- spl_driver_tb_top.sv
// Bench for spl_driver: host model drives pins, bench checks sinks.
// Assumes the checker binds itself into the driver.
`timescale 1ns/100ps
module spl_driver_tb_top;
    logic mclk, reset_n, clear_n, blank, ser_in, shift_clk, strobe_in, ser_out, early;
    logic seen = 0;
    logic [3:0] lo_o, lo_oe_n, hi_o, hi_oe_n;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    spl_host_model i_host (.mclk(mclk), .ser(ser_in), .sclk(shift_clk), .strobe(strobe_in));
    spl_driver i_dut (.MCLK(mclk), .RESET_N(reset_n), .SER_IN(ser_in), .SHIFT_CLK(shift_clk),
        .STROBE_IN(strobe_in), .CLEAR_N(clear_n), .BLANK_IN(blank),
        .SINK_DRIVE_LOW_O(lo_o), .SINK_DRIVE_LOW_OE_N(lo_oe_n), .SINK_DRIVE_HIGH_O(hi_o),
        .SINK_DRIVE_HIGH_OE_N(hi_oe_n), .SER_OUT(ser_out), .STROBE_EARLY(early));
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    // Early flag is a one-cycle pulse, so remember it
    always @(posedge mclk) begin
        cycles++;
        if (early === 1'b1) seen <= 1;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (n_fail == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic t_load();
        blank = 0;
        i_host.send(8'ha5, 0);
        i_host.wait_n(10);
        chk(~{hi_oe_n, lo_oe_n}, 8'ha5);
        chk({hi_o, lo_o}, 8'h00);
        chk({7'h0, ser_out}, 8'h01);
        i_host.send(8'h3c, 0);
        i_host.wait_n(10);
        chk(~{hi_oe_n, lo_oe_n}, 8'h3c);
        chk({6'h0, ser_out, seen}, 8'h00);
    endtask
    task automatic t_blank();
        blank = 1;
        i_host.wait_n(8);
        chk({hi_oe_n, lo_oe_n}, 8'hff);
        blank = 0;
        i_host.wait_n(8);
        chk(~{hi_oe_n, lo_oe_n}, 8'h3c);
    endtask
    task automatic t_clear();
        clear_n = 0;
        i_host.send(8'hff, 0);
        clear_n = 1;
        i_host.wait_n(10);
        chk(~{hi_oe_n, lo_oe_n}, 8'h00);
        chk({7'h0, ser_out}, 8'h00);
    endtask
    task automatic t_early();
        i_host.send(8'h81, 1);
        i_host.wait_n(10);
        chk(~{hi_oe_n, lo_oe_n}, 8'h81);
        chk({7'h0, seen}, 8'h01);
    endtask
    initial begin
        reset_n = 0;
        clear_n = 1;
        blank = 1;
        i_host.wait_n(5);
        reset_n = 1;
        i_host.wait_n(2);
        t_load();
        t_blank();
        t_clear();
        t_early();
        wrap_up();
    end
endmodule // spl_driver_tb_top
